// >>> rtl/usm_mac_ll.sv
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
// What this block does
// RULE_01 unsigned byte times signed byte, widened to 32 bits, added into accumulator
// RULE_02 start vector is select value plus offset, modulo per-group stride
// RULE_03 select register is general register 8 to 11, prefix 010
// RULE_04 offset is field times four; wide field for one group, narrow otherwise
// RULE_05 one, two or four groups; advance working vector by stride per group
// RULE_06 start vector rounded down to a multiple of four
// RULE_07 sub-vector i takes byte lane 4e+i into accumulator vector start+i
// RULE_08 products truncated to 32 bits, sums wrap, no saturation or flags
// RULE_09 single form: first sources consecutive modulo 32, second one register
// RULE_10 single form second source is zero bit plus 4-bit field
// RULE_11 single form any group count, or one group: first source field used directly
// RULE_12 indexed form: byte at four times segment base plus index
// RULE_13 multi form pairs distinct second source per group, two or four only
// RULE_14 four-group multi form appends two zero bits to both fields
// RULE_15 undefined when the second matrix extension version is absent
// RULE_16 no predicate masking, every element processed
// RULE_17 trap unless streaming vector mode and matrix array are enabled
// RULE_18 valid starts an operation, done marks the last accumulator write
module usm_mac_ll
	import usm_pkg::*;
#(
	parameter  int VL_BITS = 128,
	localparam int ZA_VECS = VL_BITS / BYTE_W,
	localparam int ZW      = $clog2(ZA_VECS)
) (
	input  wire logic                 clk_in,
	input  wire logic                 srst_in,
	input  wire logic                 op_valid_in,
	output      logic                 op_ready_out,
	input  wire logic [1:0]           form_in,
	input  wire logic [1:0]           group_in,
	input  wire logic [1:0]           vector_select_field_in,
	input  wire logic [1:0]           offset_field_wide_in,
	input  wire logic                 offset_field_narrow_in,
	input  wire logic [4:0]           first_source_field_in,
	input  wire logic [3:0]           second_source_field_in,
	input  wire logic [3:0]           index_in,
	input  wire logic                 streaming_en_in,
	input  wire logic                 za_en_in,
	output      logic [4:0]           gpr_idx_out,
	input  wire logic [GPR_W-1:0]     gpr_data_in,
	output      logic [4:0]           vreg_a_idx_out,
	output      logic [4:0]           vreg_b_idx_out,
	input  wire logic [VL_BITS-1:0]   vreg_a_in,
	input  wire logic [VL_BITS-1:0]   vreg_b_in,
	output      logic [ZW-1:0]        za_rd_idx_out,
	input  wire logic [VL_BITS-1:0]   za_rd_data_in,
	output      logic                 za_wr_en_out,
	output      logic [ZW-1:0]        za_wr_idx_out,
	output      logic [VL_BITS-1:0]   za_wr_data_out,
	output      logic                 done_out,
	output      logic                 undef_out,
	output      logic                 trap_out,
	input  wire logic [ADDR_W-1:0]    reg_addr_in,
	input  wire logic [31:0]          reg_wdata_in,
	input  wire logic                 reg_wr_in,
	input  wire logic                 reg_rd_in,
	output      logic [31:0]          reg_rdata_out,
	output      logic                 irq_out
);

	// ----------------------------------------
	// byte-lane multiply-accumulate
	// ----------------------------------------
	function automatic logic [VL_BITS-1:0] mac_vec(
		input logic [VL_BITS-1:0] acc,
		input logic [VL_BITS-1:0] a,
		input logic [VL_BITS-1:0] b,
		input logic [1:0]         sub,
		input logic               idx_mode,
		input logic [3:0]         idx
	);
		logic [VL_BITS-1:0] res;
		logic [ELEM_W-1:0]  prod;
		logic [7:0]         ua;
		logic [7:0]         sb;
		int                 la;
		int                 lb;
		res = '0;
		// every element, no predicate
		for (int e = 0; e < VL_BITS / ELEM_W; e++) begin // RULE_16
			la = SUBS * e + int'(sub); // RULE_07
			lb = idx_mode ? SUBS * (e - (e % SEG_ELEMS)) + int'(idx) : la; // RULE_12
			ua = a[la*BYTE_W +: BYTE_W];
			sb = b[lb*BYTE_W +: BYTE_W];
			prod = ELEM_W'($signed({1'b0, ua}) * $signed(sb)); // RULE_01 RULE_08
			res[e*ELEM_W +: ELEM_W] = acc[e*ELEM_W +: ELEM_W] + prod; // RULE_08
		end
		return res;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	usm_state_type      state_r;
	logic               op_ready_r;
	logic [1:0]         form_r;
	logic [1:0]         gsh_r;
	logic [4:0]         n_base_r;
	logic [4:0]         m_base_r;
	logic [3:0]         off_r;
	logic [3:0]         index_r;
	logic [1:0]         grp_r;
	logic [1:0]         sub_r;
	logic [ZW-1:0]      vec_r;
	logic [4:0]         gpr_idx_r;
	logic [4:0]         vreg_a_r;
	logic [4:0]         vreg_b_r;
	logic [ZW-1:0]      za_rd_r;
	logic               za_wr_en_r;
	logic [ZW-1:0]      za_wr_idx_r;
	logic [VL_BITS-1:0] za_wr_data_r;
	logic               done_r;
	logic               undef_r;
	logic               trap_r;
	logic               ctrl_v2_r;
	logic [EVT_W-1:0]   irq_st_r;
	logic [EVT_W-1:0]   irq_en_r;
	logic               irq_r;
	logic [31:0]        rdata_r;
	logic [CNT_W-1:0]   op_cnt_r;

	logic               accept_c;
	logic               illegal_c;
	logic               blocked_c;
	logic               last_c;
	logic [1:0]         last_grp_c;
	logic [ZW-1:0]      stride_c;
	logic [ZW-1:0]      mask_c;
	logic [GPR_W-1:0]   sum_c;
	logic [ZW-1:0]      vs_c;
	logic [1:0]         gsh_in_c;
	logic [4:0]         n_in_c;
	logic [4:0]         m_in_c;
	logic [EVT_W-1:0]   evt_c;
	logic               clr_wr_c;

	// ----------------------------------------
	// decode of the request
	// ----------------------------------------
	assign accept_c  = op_valid_in && op_ready_r;
	assign gsh_in_c  = group_in;
	assign illegal_c = !ctrl_v2_r || (form_in == FORM_BAD) || (group_in == GRP_BAD) // RULE_15
		|| (form_in == FORM_MULTI && group_in == GRP_1); // RULE_13
	assign blocked_c = !(streaming_en_in && za_en_in); // RULE_17

	always_comb begin
		// single form and one-group forms keep the field, others align it
		n_in_c = first_source_field_in; // RULE_11
		if (form_in != FORM_SINGLE && group_in == GRP_2) begin
			n_in_c = {first_source_field_in[3:0], 1'b0};
		end else if (form_in != FORM_SINGLE && group_in == GRP_4) begin
			n_in_c = {first_source_field_in[2:0], 2'b00}; // RULE_14
		end
		m_in_c = {1'b0, second_source_field_in}; // RULE_10
		if (form_in == FORM_MULTI && group_in == GRP_2) begin
			m_in_c = {second_source_field_in, 1'b0}; // RULE_13
		end else if (form_in == FORM_MULTI && group_in == GRP_4) begin
			m_in_c = {second_source_field_in[2:0], 2'b00}; // RULE_14
		end
	end

	// ----------------------------------------
	// start vector and group stepping
	// ----------------------------------------
	assign stride_c   = ZW'(ZA_VECS >> gsh_r); // RULE_02
	assign mask_c     = ZW'((ZA_VECS >> gsh_r) - 1);
	assign sum_c      = gpr_data_in + GPR_W'(off_r);
	assign vs_c       = sum_c[ZW-1:0] & mask_c & ~ZW'(SUBS - 1); // RULE_02 RULE_06
	assign last_grp_c = 2'((1 << gsh_r) - 1); // RULE_05
	assign last_c     = (grp_r == last_grp_c) && (sub_r == SUB_LAST);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			state_r    <= S_IDLE;
			op_ready_r <= 1'b0;
			grp_r      <= 2'h0;
			sub_r      <= 2'h0;
			vec_r      <= '0;
		end else begin
			unique case (state_r)
				S_IDLE: begin
					op_ready_r <= 1'b1;
					if (accept_c && !illegal_c && !blocked_c) begin
						state_r    <= S_GPR;
						op_ready_r <= 1'b0;
					end
				end
				S_GPR: begin
					state_r <= S_VEC;
				end
				S_VEC: begin
					state_r <= S_ADDR;
					grp_r   <= 2'h0;
					sub_r   <= 2'h0;
					vec_r   <= vs_c;
				end
				S_ADDR: begin
					state_r <= S_DATA;
				end
				S_DATA: begin
					sub_r <= sub_r + 2'h1;
					if (sub_r == SUB_LAST) begin
						grp_r <= grp_r + 2'h1;
						vec_r <= vec_r + stride_c; // RULE_05
					end
					if (last_c) begin
						state_r    <= S_IDLE;
						op_ready_r <= 1'b1;
					end else begin
						state_r <= S_ADDR;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// captured operation fields
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			form_r    <= FORM_SINGLE;
			gsh_r     <= GRP_1;
			n_base_r  <= '0;
			m_base_r  <= '0;
			off_r     <= '0;
			index_r   <= '0;
			gpr_idx_r <= '0;
		end else if (accept_c) begin
			form_r    <= form_in;
			gsh_r     <= gsh_in_c;
			n_base_r  <= n_in_c;
			m_base_r  <= m_in_c;
			index_r   <= index_in;
			gpr_idx_r <= {SEL_PREFIX, vector_select_field_in}; // RULE_03
			if (group_in == GRP_1) begin
				off_r <= {offset_field_wide_in, 2'b00}; // RULE_04
			end else begin
				off_r <= {1'b0, offset_field_narrow_in, 2'b00}; // RULE_04
			end
		end
	end

	// ----------------------------------------
	// operand addresses
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			vreg_a_r <= '0;
			vreg_b_r <= '0;
			za_rd_r  <= '0;
		end else if (state_r == S_VEC) begin
			vreg_a_r <= n_base_r;
			vreg_b_r <= m_base_r;
			za_rd_r  <= vs_c;
		end else if (state_r == S_DATA && !last_c) begin
			if (sub_r == SUB_LAST) begin
				vreg_a_r <= vreg_a_r + 5'h1; // RULE_09
				if (form_r == FORM_MULTI) begin
					vreg_b_r <= vreg_b_r + 5'h1; // RULE_13
				end
				za_rd_r <= vec_r + stride_c;
			end else begin
				za_rd_r <= za_rd_r + ZW'(1); // RULE_07
			end
		end
	end

	// ----------------------------------------
	// accumulator write-back
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			za_wr_en_r   <= 1'b0;
			za_wr_idx_r  <= '0;
			za_wr_data_r <= '0;
			done_r       <= 1'b0;
		end else begin
			za_wr_en_r <= (state_r == S_DATA);
			done_r     <= (state_r == S_DATA) && last_c; // RULE_18
			if (state_r == S_DATA) begin
				za_wr_idx_r  <= za_rd_r;
				za_wr_data_r <= mac_vec(za_rd_data_in, vreg_a_in, vreg_b_in, sub_r,
					form_r == FORM_INDEX, index_r); // RULE_01
			end
		end
	end

	// ----------------------------------------
	// fault pulses
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			undef_r <= 1'b0;
			trap_r  <= 1'b0;
		end else begin
			undef_r <= accept_c && illegal_c; // RULE_15
			trap_r  <= accept_c && !illegal_c && blocked_c; // RULE_17
		end
	end

	// ----------------------------------------
	// interrupt status, set wins over clear
	// ----------------------------------------
	assign evt_c    = {trap_r, undef_r, done_r};
	assign clr_wr_c = reg_wr_in && (reg_addr_in == ADDR_IRQ_CLR);

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			irq_st_r <= '0;
			irq_r    <= 1'b0;
		end else begin
			if (clr_wr_c) begin
				irq_st_r <= (irq_st_r & ~reg_wdata_in[EVT_W-1:0]) | evt_c;
			end else begin
				irq_st_r <= irq_st_r | evt_c;
			end
			irq_r <= |(irq_st_r & irq_en_r);
		end
	end

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ctrl_v2_r <= CTRL_V2_RST;
			irq_en_r  <= '0;
		end else if (reg_wr_in) begin
			if (reg_addr_in == ADDR_CTRL) begin
				ctrl_v2_r <= reg_wdata_in[CTRL_V2_BIT];
			end
			if (reg_addr_in == ADDR_IRQ_EN) begin
				irq_en_r <= reg_wdata_in[EVT_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			op_cnt_r <= '0;
		end else if (done_r) begin
			op_cnt_r <= op_cnt_r + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= '0;
			if (reg_rd_in) begin
				unique case (reg_addr_in)
					ADDR_CTRL: begin
						rdata_r[CTRL_V2_BIT] <= ctrl_v2_r;
					end
					ADDR_STATUS: begin
						rdata_r[STAT_BUSY] <= (state_r != S_IDLE);
						rdata_r[STAT_CNT_LSB +: CNT_W] <= op_cnt_r;
					end
					ADDR_IRQ_ST: begin
						rdata_r[EVT_W-1:0] <= irq_st_r;
					end
					ADDR_IRQ_EN: begin
						rdata_r[EVT_W-1:0] <= irq_en_r;
					end
					default: begin
						rdata_r <= '0;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign op_ready_out   = op_ready_r;
	assign gpr_idx_out    = gpr_idx_r;
	assign vreg_a_idx_out = vreg_a_r;
	assign vreg_b_idx_out = vreg_b_r;
	assign za_rd_idx_out  = za_rd_r;
	assign za_wr_en_out   = za_wr_en_r;
	assign za_wr_idx_out  = za_wr_idx_r;
	assign za_wr_data_out = za_wr_data_r;
	assign done_out       = done_r;
	assign undef_out      = undef_r;
	assign trap_out       = trap_r;
	assign reg_rdata_out  = rdata_r;
	assign irq_out        = irq_r;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking ck @(posedge clk_in);
	endclocking
	default disable iff (srst_in);

	// writes already made before the current one; wide enough for four groups
	logic [4:0] wr_cnt_r;
	always_ff @(posedge clk_in) begin
		if (srst_in || accept_c) begin
			wr_cnt_r <= '0;
		end else if (za_wr_en_r) begin
			wr_cnt_r <= wr_cnt_r + 5'h1;
		end
	end

	sequence grp_step_s;
		(state_r == S_DATA && sub_r == SUB_LAST && !last_c) ##1 (state_r == S_ADDR);
	endsequence

	sequence start_s;
		accept_c && !illegal_c && !blocked_c;
	endsequence

	undef_pulse_a: assert property (accept_c && illegal_c |=> undef_out && !trap_out) // RULE_15
		else $error("undefined request not flagged");
	trap_pulse_a: assert property (accept_c && !illegal_c && blocked_c |=> trap_out) // RULE_17
		else $error("disabled request not trapped");
	sel_reg_a: assert property (start_s |=> gpr_idx_out[4:2] == SEL_PREFIX) // RULE_03
		else $error("select register outside 8 to 11");
	wr_follow_a: assert property (state_r == S_DATA |=> za_wr_en_out && za_wr_idx_out == $past(za_rd_idx_out)) // RULE_07
		else $error("write does not follow read");
	start_align_a: assert property (state_r == S_ADDR && sub_r == 2'h0 |-> za_rd_idx_out[1:0] == 2'h0) // RULE_06
		else $error("group start not aligned");
	write_count_a: assert property (done_out |-> za_wr_en_out && wr_cnt_r + 5'h1 == 5'(SUBS << gsh_r)) // RULE_05
		else $error("wrong number of writes at done");
	src_step_a: assert property (grp_step_s |-> vreg_a_idx_out == 5'($past(vreg_a_idx_out, 2) + 5'h1)) // RULE_09
		else $error("first source not consecutive");
	low_second_a: assert property (state_r == S_ADDR && form_r != FORM_MULTI |-> !vreg_b_idx_out[4]) // RULE_10
		else $error("second source above 15");
	busy_done_a: assert property (start_s |-> ##[4:40] done_out) // RULE_18
		else $error("operation did not finish");

endmodule

// >>> rtl/usm_pkg.sv
package usm_pkg;
	// ----------------------------------------
	// data shape
	// ----------------------------------------
	localparam int BYTE_W    = 8;
	localparam int ELEM_W    = 32;
	localparam int SEG_W     = 128;
	localparam int SEG_ELEMS = SEG_W / ELEM_W;
	localparam int SUBS      = 4;
	localparam int GPR_W     = 32;
	localparam int REG_IDX_W = 5;

	// ----------------------------------------
	// operation encodings
	// ----------------------------------------
	localparam logic [2:0] SEL_PREFIX  = 3'h2;
	localparam logic [1:0] FORM_SINGLE = 2'h0;
	localparam logic [1:0] FORM_INDEX  = 2'h1;
	localparam logic [1:0] FORM_MULTI  = 2'h2;
	localparam logic [1:0] FORM_BAD    = 2'h3;
	localparam logic [1:0] GRP_1       = 2'h0;
	localparam logic [1:0] GRP_2       = 2'h1;
	localparam logic [1:0] GRP_4       = 2'h2;
	localparam logic [1:0] GRP_BAD     = 2'h3;
	localparam logic [1:0] SUB_LAST    = 2'h3;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int         ADDR_W       = 8;
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_IRQ_ST  = 8'h08;
	localparam logic [7:0] ADDR_IRQ_EN  = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
	localparam int         CTRL_V2_BIT  = 0;
	localparam logic       CTRL_V2_RST  = 1'h1;
	localparam int         STAT_BUSY    = 0;
	localparam int         STAT_CNT_LSB = 16;
	localparam int         CNT_W        = 16;
	localparam int         EVT_DONE     = 0;
	localparam int         EVT_UNDEF    = 1;
	localparam int         EVT_TRAP     = 2;
	localparam int         EVT_W        = 3;

	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_GPR  = 5'h02,
		S_VEC  = 5'h04,
		S_ADDR = 5'h08,
		S_DATA = 5'h10
	} usm_state_type;
endpackage

// >>> bench/usm_partner.sv
`timescale 1ns/1ps
module usm_partner
	import usm_pkg::*;
#(
	parameter int	VL_BITS	= 128,
	parameter int	ZW	= 4
) (
	input	wire logic			clk_in,
	input	wire logic [4:0]		gpr_idx_in,
	output	logic [GPR_W-1:0]		gpr_data_out,
	input	wire logic [4:0]		vreg_a_idx_in,
	input	wire logic [4:0]		vreg_b_idx_in,
	output	logic [VL_BITS-1:0]		vreg_a_out,
	output	logic [VL_BITS-1:0]		vreg_b_out,
	input	wire logic [ZW-1:0]		za_rd_idx_in,
	output	logic [VL_BITS-1:0]		za_rd_data_out,
	input	wire logic			za_wr_en_in,
	input	wire logic [ZW-1:0]		za_wr_idx_in,
	input	wire logic [VL_BITS-1:0]	za_wr_data_in
);
	logic [GPR_W-1:0]	gpr [32];
	logic [VL_BITS-1:0]	vreg [32];
	logic [VL_BITS-1:0]	za [2**ZW];

	// ----------
	// register files and accumulator array, one cycle read latency
	// ----------
	always @(posedge clk_in) begin
		gpr_data_out <= gpr[gpr_idx_in];
		vreg_a_out <= vreg[vreg_a_idx_in];
		vreg_b_out <= vreg[vreg_b_idx_in];
		za_rd_data_out <= za[za_rd_idx_in];
		if (za_wr_en_in) begin
			za[za_wr_idx_in] <= za_wr_data_in;
		end
	end
endmodule

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench
	import usm_pkg::*;
;
	localparam int	VL	= 256;
	localparam int	NV	= VL / BYTE_W;
	localparam int	ZWB	= $clog2(NV);

	logic			clk_in, srst_in, op_valid_in, op_ready_out;
	logic [1:0]		form_in, group_in, vector_select_field_in, offset_field_wide_in;
	logic			offset_field_narrow_in, streaming_en_in, za_en_in;
	logic [4:0]		first_source_field_in, gpr_idx_out, vreg_a_idx_out, vreg_b_idx_out;
	logic [3:0]		second_source_field_in, index_in;
	logic [GPR_W-1:0]	gpr_data_in;
	logic [VL-1:0]		vreg_a_in, vreg_b_in, za_rd_data_in, za_wr_data_out;
	logic [ZWB-1:0]		za_rd_idx_out, za_wr_idx_out;
	logic			za_wr_en_out, done_out, undef_out, trap_out, reg_wr_in, reg_rd_in, irq_out;
	logic [ADDR_W-1:0]	reg_addr_in;
	logic [31:0]		reg_wdata_in, reg_rdata_out;
	logic [VL-1:0]		exp_za [NV];
	int			num_errors, checked;

	usm_mac_ll #(.VL_BITS(VL)) u_usm_mac_ll (.clk_in, .srst_in, .op_valid_in, .op_ready_out, .form_in,
		.group_in, .vector_select_field_in, .offset_field_wide_in, .offset_field_narrow_in,
		.first_source_field_in, .second_source_field_in, .index_in, .streaming_en_in, .za_en_in,
		.gpr_idx_out, .gpr_data_in, .vreg_a_idx_out, .vreg_b_idx_out, .vreg_a_in, .vreg_b_in,
		.za_rd_idx_out, .za_rd_data_in, .za_wr_en_out, .za_wr_idx_out, .za_wr_data_out, .done_out,
		.undef_out, .trap_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .irq_out);

	usm_partner #(.VL_BITS(VL), .ZW(ZWB)) u_usm_partner (.clk_in(clk_in), .gpr_idx_in(gpr_idx_out),
		.gpr_data_out(gpr_data_in), .vreg_a_idx_in(vreg_a_idx_out), .vreg_b_idx_in(vreg_b_idx_out),
		.vreg_a_out(vreg_a_in), .vreg_b_out(vreg_b_in), .za_rd_idx_in(za_rd_idx_out),
		.za_rd_data_out(za_rd_data_in), .za_wr_en_in(za_wr_en_out), .za_wr_idx_in(za_wr_idx_out),
		.za_wr_data_in(za_wr_data_out));

	// ----------
	// shared tasks
	// ----------
	task automatic check(input string what, input logic [VL-1:0] exp, input logic [VL-1:0] got);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic cmp_za();
		for (int v = 0; v < NV; v++) begin
			check($sformatf("za vector %0d", v), exp_za[v], u_usm_partner.za[v]);
		end
	endtask

	task automatic reg_wr(input logic [7:0] addr, input logic [31:0] data);
		@(posedge clk_in);
		reg_wr_in <= 1'b1;
		reg_addr_in <= addr;
		reg_wdata_in <= data;
		@(posedge clk_in);
		reg_wr_in <= 1'b0;
	endtask

	task automatic reg_chk(input logic [7:0] addr, input logic [31:0] exp);
		@(posedge clk_in);
		reg_rd_in <= 1'b1;
		reg_addr_in <= addr;
		@(posedge clk_in);
		reg_rd_in <= 1'b0;
		#1;
		check($sformatf("register %h", addr), exp, reg_rdata_out);
	endtask

	// reference accumulation into exp_za, from the partner's operand contents
	task automatic model(input logic [1:0] form, grp, sel, offw, input logic offn, input logic [4:0] zn,
		input logic [3:0] zm, idx);
		int		nn, vs, vec, n, m;
		logic [VL-1:0]	a, b;
		logic [7:0]	sb;
		logic [31:0]	p;
		nn = (grp == GRP_1) ? 1 : (grp == GRP_2) ? 2 : 4;
		vs = NV / nn;
		vec = int'((longint'(u_usm_partner.gpr[{SEL_PREFIX, sel}]) + (nn == 1 ? 4 * offw : 4 * offn)) % vs);
		vec -= vec % 4;
		n = zn;
		if (form == FORM_MULTI || (form == FORM_INDEX && nn > 1)) begin
			n = (nn == 2) ? {zn[3:0], 1'b0} : {zn[2:0], 2'b00};
		end
		m = (form != FORM_MULTI) ? zm : (nn == 2) ? {zm[3:0], 1'b0} : {zm[2:0], 2'b00};
		for (int r = 0; r < nn; r++) begin
			a = u_usm_partner.vreg[(n + r) % 32];
			b = u_usm_partner.vreg[form == FORM_MULTI ? m + r : m];
			for (int i = 0; i < SUBS; i++) begin
				for (int e = 0; e < VL / ELEM_W; e++) begin
					sb = (form == FORM_INDEX) ? b[8 * (4 * (e - e % SEG_ELEMS) + idx) +: 8] : b[8 * (4 * e + i) +: 8];
					p = {24'h0, a[8 * (4 * e + i) +: 8]} * {{24{sb[7]}}, sb};
					exp_za[vec + i][32 * e +: 32] += p;
				end
			end
			vec += vs;
		end
	endtask

	// valid is held until the last request is accepted; reps 2 gets taken again on the done cycle
	task automatic run_op(input logic [1:0] form, grp, sel, offw, input logic offn, input logic [4:0] zn,
		input logic [3:0] zm, idx, input int reps);
		int nn, k, first, dn, wr;
		nn = (grp == GRP_1) ? 1 : (grp == GRP_2) ? 2 : 4;
		first = -1;
		dn = 0;
		wr = 0;
		for (int r = 0; r < reps; r++) begin
			model(form, grp, sel, offw, offn, zn, zm, idx);
		end
		@(posedge clk_in);
		op_valid_in <= 1'b1;
		form_in <= form;
		group_in <= grp;
		vector_select_field_in <= sel;
		offset_field_wide_in <= offw;
		offset_field_narrow_in <= offn;
		first_source_field_in <= zn;
		second_source_field_in <= zm;
		index_in <= idx;
		for (k = 0; k < 400 && dn < reps; k++) begin
			@(posedge clk_in);
			if (k == (reps - 1) * (3 + 8 * nn)) begin
				op_valid_in <= 1'b0;
			end
			#1;
			if (k == 1) begin
				check("ready while busy", 0, op_ready_out);
			end
			wr += za_wr_en_out;
			if (done_out === 1'b1) begin
				first = (first < 0) ? k : first;
				dn++;
			end
		end
		check("done latency", 2 + 8 * nn, first);
		check("write count", 4 * nn * reps, wr);
		check("ready at done", 1, op_ready_out);
		// the last write lands in the array at the edge after done
		@(posedge clk_in);
		#1;
		cmp_za();
	endtask

	task automatic bad_op(input logic [1:0] form, grp, input logic s_en, z_en, input logic [1:0] exp_ut);
		@(posedge clk_in);
		op_valid_in <= 1'b1;
		form_in <= form;
		group_in <= grp;
		streaming_en_in <= s_en;
		za_en_in <= z_en;
		@(posedge clk_in);
		op_valid_in <= 1'b0;
		streaming_en_in <= 1'b1;
		za_en_in <= 1'b1;
		#1;
		check("undef and trap", exp_ut, {undef_out, trap_out});
		check("ready kept", 1, op_ready_out);
		@(posedge clk_in);
		#1;
		check("pulse end", 0, {undef_out, trap_out, za_wr_en_out});
	endtask

	// ----------
	// scenarios
	// ----------
	task automatic t_reset();
		repeat (8) @(posedge clk_in);
		srst_in <= 1'b0;
		@(posedge clk_in);
		#1;
		check("ready after reset", 1, op_ready_out);
		check("irq after reset", 0, irq_out);
		reg_chk(ADDR_CTRL, 32'h0000_0001);
		reg_chk(ADDR_IRQ_EN, 32'h0);
		reg_wr(ADDR_STATUS, 32'hffff_ffff);
		reg_chk(ADDR_STATUS, 32'h0);
		reg_chk(8'h14, 32'h0);
	endtask

	task automatic t_single_one();
		run_op(FORM_SINGLE, GRP_1, 2'h2, 2'h3, 1'b0, 5'h1d, 4'hf, 4'h0, 1);
	endtask

	task automatic t_single_four();
		run_op(FORM_SINGLE, GRP_4, 2'h1, 2'h0, 1'b1, 5'h1e, 4'h3, 4'h0, 1);
	endtask

	task automatic t_single_chain();
		run_op(FORM_SINGLE, GRP_2, 2'h0, 2'h0, 1'b0, 5'h07, 4'h9, 4'h0, 2);
	endtask

	task automatic t_indexed();
		for (int g = 0; g < 3; g++) begin
			run_op(FORM_INDEX, 2'(g), 2'h3, 2'h1, 1'b1, 5'h05, 4'he, 4'(13 - 5 * g), 1);
		end
	endtask

	task automatic t_multi();
		for (int g = 1; g < 3; g++) begin
			run_op(FORM_MULTI, 2'(g), 2'h0, 2'h0, 1'b1, 5'h09, 4'h6, 4'h0, 1);
		end
	endtask

	task automatic t_irq_done();
		reg_chk(ADDR_STATUS, 32'h0009_0000);
		reg_chk(ADDR_IRQ_ST, 32'h1);
		check("irq masked", 0, irq_out);
		reg_wr(ADDR_IRQ_EN, 32'h1);
		repeat (2) @(posedge clk_in);
		#1;
		check("irq enabled", 1, irq_out);
		reg_wr(ADDR_IRQ_CLR, 32'h1);
		repeat (2) @(posedge clk_in);
		#1;
		check("irq cleared", 0, irq_out);
		reg_chk(ADDR_IRQ_ST, 32'h0);
	endtask

	task automatic t_refused();
		bad_op(FORM_BAD, GRP_1, 1'b1, 1'b1, 2'h2);
		bad_op(FORM_SINGLE, GRP_BAD, 1'b1, 1'b1, 2'h2);
		bad_op(FORM_MULTI, GRP_1, 1'b1, 1'b1, 2'h2);
		bad_op(FORM_BAD, GRP_1, 1'b0, 1'b1, 2'h2);
		bad_op(FORM_SINGLE, GRP_1, 1'b0, 1'b1, 2'h1);
		bad_op(FORM_INDEX, GRP_2, 1'b1, 1'b0, 2'h1);
		reg_wr(ADDR_CTRL, 32'h0);
		bad_op(FORM_MULTI, GRP_4, 1'b1, 1'b1, 2'h2);
		reg_wr(ADDR_CTRL, 32'h1);
		reg_wr(ADDR_IRQ_EN, 32'h6);
		repeat (2) @(posedge clk_in);
		#1;
		check("irq on faults", 1, irq_out);
		reg_chk(ADDR_IRQ_ST, 32'h6);
		cmp_za();
	endtask

	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end

	// bails out of a hung handshake, runs far longer than the tests need
	initial begin
		#500000;
		num_errors++;
		summarize();
	end

	initial begin
		{srst_in, op_valid_in, reg_wr_in, reg_rd_in} = 4'h8;
		{streaming_en_in, za_en_in} = 2'h3;
		{form_in, group_in, vector_select_field_in, offset_field_wide_in, offset_field_narrow_in} = 9'h0;
		{first_source_field_in, second_source_field_in, index_in} = 13'h0;
		reg_addr_in = 8'h00;
		reg_wdata_in = 32'h0;
		num_errors = 0;
		checked = 0;
		for (int r = 0; r < 32; r++) begin
			u_usm_partner.gpr[r] = 32'(r * 3 + 1);
			for (int j = 0; j < VL / 8; j++) begin
				u_usm_partner.vreg[r][8 * j +: 8] = 8'(r * 37 + j * 29 + 128);
			end
		end
		u_usm_partner.gpr[8] = 32'h0000_001f;
		u_usm_partner.gpr[9] = 32'h0000_0013;
		u_usm_partner.gpr[10] = 32'h8000_0005;
		u_usm_partner.gpr[11] = 32'hffff_fffe;
		for (int v = 0; v < NV; v++) begin
			u_usm_partner.za[v] = {(VL / 32){32'hffff_ff00 + 32'(v)}};
			exp_za[v] = u_usm_partner.za[v];
		end
		t_reset();
		t_single_one();
		t_single_four();
		t_single_chain();
		t_indexed();
		t_multi();
		t_irq_done();
		t_refused();
		summarize();
	end
endmodule
